// ===== pkg/cct_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the timer block
// Assumes: 32-bit classic wishbone, byte addresses, one word per register
// Notes: included by bare name
`ifndef CCT_DEFS_SVH
`define CCT_DEFS_SVH

// register byte offsets
`define CCT_A_CMP_HI 8'h00
`define CCT_A_CMP_LO 8'h04
`define CCT_A_TMR_HI 8'h08
`define CCT_A_TMR_LO 8'h0c
`define CCT_A_CTRL 8'h10
`define CCT_A_STAT 8'h14
`define CCT_A_ICLR 8'h18
`define CCT_A_IEN 8'h1c

// control register fields
`define CCT_B_EXT_MASK 0
`define CCT_B_CC_MASK 1
`define CCT_B_TM_MASK 2

// status register fields: sticky events low, live conditions above
`define CCT_B_CC_EV 0
`define CCT_B_TM_EV 1
`define CCT_B_CC_LIVE 2
`define CCT_B_TM_LIVE 3

// reset values
`define CCT_RST_64 64'h0000_0000_0000_0000
`define CCT_RST_32 32'h0000_0000

// compared span: positions 0..51 counted from the msb are [63:12]
`define CCT_CMP_LSB 12
// one microsecond in the doubleword format is bit 51, weight 2**12
`define CCT_TMR_STEP 64'h0000_0000_0000_1000

// time base
`define CCT_US_NS 1000
`define CCT_CLK_NS 20
`define CCT_US_CYC (`CCT_US_NS / `CCT_CLK_NS)

`endif

// ===== pkg/cct_pkg.sv
// Purpose: shared types of the comparator and cpu timer block
// Assumes: constants live in cct_defs.svh
// Notes: packed structs carry grouped bits
`default_nettype none
package cct_pkg;

    // software masks held in the control register
    typedef struct packed {
        logic tm_mask;
        logic cc_mask;
        logic ext_mask;
    } cct_ctrl_s;

    // sticky interrupt sources, same layout in status, clear and enable
    typedef struct packed {
        logic tm_ev;
        logic cc_ev;
    } cct_ev_s;

    // external interruption requests after all masking
    typedef struct packed {
        logic tm_req;
        logic cc_req;
    } cct_req_s;

endpackage
`default_nettype wire

// ===== rtl/cct_tick.sv
// Purpose: divides the system clock down to a one-cycle microsecond strobe
// Assumes: clock period divides one microsecond evenly
// Notes: the strobe is shared by the time-of-day clock and the cpu timer
`timescale 1ns/10ps
`default_nettype none
module cct_tick #(
    parameter int CYC = 50
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    output logic tick_o
);
    logic [6:0] cnt_q;

    // free-running divider, strobe on wrap
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_q <= 7'h00;
            tick_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (cnt_q == 7'(CYC - 1))
            begin
                cnt_q <= 7'h00;
                tick_o <= 1'b1;
            end
            else
            begin
                cnt_q <= cnt_q + 7'h01;
                tick_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtl/cct_top.sv
// Purpose: clock comparator and signed cpu timer with wishbone registers
// Assumes: time-of-day value arrives on tod_i and steps on tod_step_o
// Notes: 64-bit values are set by writing HI then LO; LO commits
//
// Behaviour
// - comparator uses clock format, cleared on reset
// - set-comparator loads supplied time value
// - store-comparator reads without altering
// - request when clock exceeds comparator, masked
// - compare only positions 0 through 51
// - masked condition clears when clock drops back
// - comparison runs on even while stopped
// - timer is clock format, msb is sign
// - timer steps down once per microsecond
// - timer and clock share one time base
// - timer cleared on initial program reset
// - set-timer loads supplied interval value
// - store-timer returns current timer value
// - timer requests while negative, masked
// - counts running and waiting, holds when stopped
// - positive load drops pending timer request
//
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "cct_defs.svh"
module cct_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // cpu side
    input wire logic [63:0] tod_i,
    input wire logic ipr_i,
    input wire logic cpu_stopped_i,
    output logic tod_step_o,
    output var cct_pkg::cct_req_s ext_req_o,
    output logic ext_int_o,
    output logic irq_o
);
    import cct_pkg::*;

    logic [63:0] cmp_q;
    logic [63:0] tmr_q;
    logic [31:0] hold_q;
    logic [31:0] rd_lo_q;
    cct_ctrl_s ctrl_q;
    cct_ev_s stat_q;
    cct_ev_s ien_q;
    logic cc_cond_q;
    logic tm_neg_d;
    logic cc_gt_d;
    logic tick;
    logic acc;
    logic wr;
    logic rd;
    logic [7:0] adr;
    logic [31:0] wdat;
    logic [31:0] rdat_d;
    logic wr_cmp;
    logic wr_tmr;

    // merge of byte lanes into an existing word
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                r[8*i +: 8] = nw[8*i +: 8];
        end
        return r;
    endfunction

    // microsecond strobe driving both tod stepping and the timer
    cct_tick #(
        .CYC(`CCT_US_CYC)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tick_o(tick)
    );
    assign tod_step_o = tick;

    // bus decode; a request is served on the edge that raises ack
    assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = acc & wb_we_i;
    assign rd = acc & ~wb_we_i;
    assign adr = {wb_adr_i[7:2], 2'b00};
    assign wdat = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
    assign wr_cmp = wr & (adr == `CCT_A_CMP_LO);
    assign wr_tmr = wr & (adr == `CCT_A_TMR_LO);

    // single-cycle ack, dropped the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else if (ce_i)
            wb_ack_o <= acc;
    end

    // high word staging for the 64-bit set operations
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            hold_q <= `CCT_RST_32;
        else if (ce_i && wr && (adr == `CCT_A_CMP_HI || adr == `CCT_A_TMR_HI))
            hold_q <= lane_merge(hold_q, wb_dat_i, wb_sel_i);
    end

    // clock comparator register
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (ce_i && ipr_i))
            cmp_q <= `CCT_RST_64;
        else if (ce_i && wr_cmp)
            cmp_q <= {hold_q, wdat};
    end

    // cpu timer: loads win over stepping, holds while stopped
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (ce_i && ipr_i))
            tmr_q <= `CCT_RST_64;
        else if (ce_i && wr_tmr)
            tmr_q <= {hold_q, wdat};
        else if (ce_i && tick && !cpu_stopped_i)
            tmr_q <= tmr_q - `CCT_TMR_STEP;
    end

    // comparison over the leading 52 bits, independent of run state
    assign cc_gt_d = tod_i[63:`CCT_CMP_LSB] > cmp_q[63:`CCT_CMP_LSB];
    assign tm_neg_d = tmr_q[63];

    // live comparator condition, follows the clock both ways
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cc_cond_q <= 1'b0;
        else if (ce_i)
            cc_cond_q <= cc_gt_d;
    end

    // gated requests toward the interruption priority logic
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_req_o <= '0;
            ext_int_o <= 1'b0;
        end
        else if (ce_i)
        begin
            ext_req_o.cc_req <= ctrl_q.ext_mask & ctrl_q.cc_mask & cc_cond_q;
            ext_req_o.tm_req <= ctrl_q.ext_mask & ctrl_q.tm_mask & tm_neg_d;
            ext_int_o <= ctrl_q.ext_mask
                & ((ctrl_q.cc_mask & cc_cond_q) | (ctrl_q.tm_mask & tm_neg_d));
        end
    end

    // control and interrupt enable registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= '0;
            ien_q <= '0;
        end
        else if (ce_i && wr && wb_sel_i[0])
        begin
            if (adr == `CCT_A_CTRL)
                ctrl_q <= wb_dat_i[2:0];
            if (adr == `CCT_A_IEN)
                ien_q <= wb_dat_i[1:0];
        end
    end

    // sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            stat_q <= '0;
        else if (ce_i)
        begin
            if (wr && wb_sel_i[0] && adr == `CCT_A_ICLR)
                stat_q <= stat_q & ~cct_ev_s'(wb_dat_i[1:0])
                    | cct_ev_s'({tm_neg_d, cc_cond_q});
            else
                stat_q <= stat_q | cct_ev_s'({tm_neg_d, cc_cond_q});
        end
    end

    // level interrupt while any enabled status bit is set
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else if (ce_i)
            irq_o <= |(stat_q & ien_q);
    end

    // read mux; reading HI snapshots LO for a consistent pair
    always_comb
    begin
        rdat_d = `CCT_RST_32;
        unique case (adr)
            `CCT_A_CMP_HI: rdat_d = cmp_q[63:32];
            `CCT_A_CMP_LO: rdat_d = rd_lo_q;
            `CCT_A_TMR_HI: rdat_d = tmr_q[63:32];
            `CCT_A_TMR_LO: rdat_d = rd_lo_q;
            `CCT_A_CTRL: rdat_d = {29'h0, ctrl_q};
            `CCT_A_STAT: rdat_d = {28'h0, tm_neg_d, cc_cond_q, stat_q};
            `CCT_A_IEN: rdat_d = {30'h0, ien_q};
            default: rdat_d = `CCT_RST_32;
        endcase
    end

    // low word snapshot taken on a HI read
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rd_lo_q <= `CCT_RST_32;
        else if (ce_i && rd && adr == `CCT_A_CMP_HI)
            rd_lo_q <= cmp_q[31:0];
        else if (ce_i && rd && adr == `CCT_A_TMR_HI)
            rd_lo_q <= tmr_q[31:0];
    end

    // registered read data, presented with ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= `CCT_RST_32;
        else if (ce_i && rd)
            wb_dat_o <= rdat_d;
    end

    // reset on ipr clears the comparator
    property p_cmp_ipr;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && ipr_i |=> cmp_q == 64'h0;
    endproperty
    a_cmp_ipr: assert property (p_cmp_ipr) else $error("comparator not cleared");

    // set-comparator takes staged high word and written low word
    property p_cmp_set;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && wr_cmp && !ipr_i && wb_sel_i == 4'hf
        |=> cmp_q == {$past(hold_q), $past(wb_dat_i)};
    endproperty
    a_cmp_set: assert property (p_cmp_set) else $error("comparator load wrong");

    // reading the comparator leaves it unchanged
    property p_cmp_read;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && rd && !ipr_i |=> $stable(cmp_q);
    endproperty
    a_cmp_read: assert property (p_cmp_read) else $error("read altered comparator");

    // masked-in comparator condition reaches the request in two cycles
    property p_cc_req;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && cc_gt_d && ctrl_q.ext_mask && ctrl_q.cc_mask ##1 ce_i && $stable(ctrl_q)
        |=> ext_req_o.cc_req && ext_int_o;
    endproperty
    a_cc_req: assert property (p_cc_req) else $error("comparator request missing");

    // low twelve bits never raise the condition
    property p_cc_span;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && tod_i[63:12] == cmp_q[63:12] |=> !cc_cond_q;
    endproperty
    a_cc_span: assert property (p_cc_span) else $error("compare used low bits");

    // pending condition drops once the clock is no longer above
    property p_cc_drop;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && cc_cond_q && !cc_gt_d |=> !cc_cond_q;
    endproperty
    a_cc_drop: assert property (p_cc_drop) else $error("comparator stuck pending");

    // timer steps by one microsecond on the shared strobe
    property p_tmr_step;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && tod_step_o && !cpu_stopped_i && !ipr_i && !wr_tmr
        |=> tmr_q == $past(tmr_q) - 64'h1000;
    endproperty
    a_tmr_step: assert property (p_tmr_step) else $error("timer step wrong");

    // reset on ipr clears the timer
    property p_tmr_ipr;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && ipr_i |=> tmr_q == 64'h0;
    endproperty
    a_tmr_ipr: assert property (p_tmr_ipr) else $error("timer not cleared");

    // stopped cpu freezes the timer
    property p_tmr_hold;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && cpu_stopped_i && !ipr_i && !wr_tmr |=> $stable(tmr_q);
    endproperty
    a_tmr_hold: assert property (p_tmr_hold) else $error("timer ran while stopped");

    // negative timer requests every cycle it stays negative
    property p_tm_level;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && tmr_q[63] && ctrl_q.ext_mask && ctrl_q.tm_mask |=> ext_req_o.tm_req;
    endproperty
    a_tm_level: assert property (p_tm_level) else $error("timer request missing");

    // positive load removes the pending timer request
    property p_tm_pos;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && wr_tmr && !ipr_i && !hold_q[31] ##1 ce_i
        |=> !ext_req_o.tm_req;
    endproperty
    a_tm_pos: assert property (p_tm_pos) else $error("positive load left request");

    // set-timer takes staged high word and written low word
    property p_tmr_set;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && wr_tmr && !ipr_i && wb_sel_i == 4'hf
        |=> tmr_q == {$past(hold_q), $past(wb_dat_i)};
    endproperty
    a_tmr_set: assert property (p_tmr_set) else $error("timer load wrong");

    // store-timer returns the live high word of the timer
    property p_tmr_read;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && rd && adr == `CCT_A_TMR_HI |=> wb_dat_o == $past(tmr_q[63:32]);
    endproperty
    a_tmr_read: assert property (p_tmr_read) else $error("timer read wrong");

    // summary mask off keeps both requests and the summary line down
    property p_ext_off;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !ctrl_q.ext_mask
        |=> !ext_req_o.cc_req && !ext_req_o.tm_req && !ext_int_o;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("request while masked");
endmodule
`default_nettype wire

// ===== verif/cct_cpu_model.sv
// Purpose: cpu side stand-in that keeps the time-of-day value
// Assumes: the value steps by one microsecond unit on the shared strobe
// Notes: a load lets the bench place the clock anywhere
`timescale 1ns/10ps
`default_nettype none
`include "cct_defs.svh"
module cct_cpu_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic step_i,
    input wire logic load_i,
    input wire logic [63:0] load_val_i,
    output logic [63:0] tod_o
);
    // clock advances on every strobe, stopped or not
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tod_o <= `CCT_RST_64;
        else if (load_i)
            tod_o <= load_val_i;
        else if (step_i)
            tod_o <= tod_o + `CCT_TMR_STEP;
    end
endmodule
`default_nettype wire

// ===== verif/cct_top_tb_top.sv
// Purpose: self-checking bench for the comparator and cpu timer
// Assumes: 50 MHz clock, time-of-day kept by cct_cpu_model
// Notes: timer checks are aligned to the microsecond strobe
`timescale 1ns/10ps
`default_nettype none
`include "cct_defs.svh"
`define CHK(nm, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            err_total++; \
            $display("Error %s exp %h got %h", nm, e, g); \
        end \
    end
module cct_top_tb_top import cct_pkg::*; ;
    logic clk_i, rst_i, ce_i, ipr, stopped, load, step, ext_int, irq;
    logic wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat, wb_rdat, rd;
    logic [63:0] tod, load_val, v;
    cct_req_s req;
    int err_total, n_tests, cyc_cnt;

    cct_top uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .tod_i(tod),
        .ipr_i(ipr), .cpu_stopped_i(stopped), .tod_step_o(step),
        .ext_req_o(req), .ext_int_o(ext_int), .irq_o(irq));
    cct_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .step_i(step), .load_i(load),
        .load_val_i(load_val), .tod_o(tod));

    // one classic cycle, held until ack is seen at an edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= we;
        wb_adr <= a;
        wb_wdat <= d;
        @(posedge clk_i);
        while (wb_ack !== 1'h1)
            @(posedge clk_i);
        rd = wb_rdat;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        wb_we <= 1'h0;
    endtask

    // doubleword set and store: high word first
    task automatic wr64(input logic [7:0] a, input logic [63:0] d);
        wb(1'h1, a, d[63:32]);
        wb(1'h1, a + 8'h04, d[31:0]);
    endtask

    task automatic rd64(input logic [7:0] a);
        wb(1'h0, a, 32'h0);
        v[63:32] = rd;
        wb(1'h0, a + 8'h04, 32'h0);
        v[31:0] = rd;
    endtask

    // returns at the edge where the strobe steps both counters
    task automatic sync;
        @(posedge clk_i);
        while (step !== 1'h1)
            @(posedge clk_i);
    endtask

    // loads the clock just after a strobe, leaving a quiet microsecond
    task automatic set_tod(input logic [63:0] t);
        sync();
        load <= 1'h1;
        load_val <= t;
        @(posedge clk_i);
        load <= 1'h0;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic wrap_up;
        if (err_total == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // free-running clock
    initial
    begin
        clk_i = 1'h0;
        forever #10 clk_i = ~clk_i;
    end

    // hang guard
    always @(posedge clk_i)
    begin
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            err_total++;
            wrap_up();
        end
    end

    // main sequence
    initial
    begin
        {rst_i, ce_i} = 2'h3;
        {ipr, stopped, load, wb_cyc, wb_stb, wb_we} = 6'h0;
        {wb_adr, wb_sel, wb_wdat, load_val} = {8'h0, 4'hf, 32'h0, 64'h0};
        {err_total, n_tests, cyc_cnt} = {32'h0, 32'h0, 32'h0};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        rd64(`CCT_A_CMP_HI);
        `CHK("cmp_rst", `CCT_RST_64, v)
        rd64(`CCT_A_TMR_HI);
        `CHK("tmr_rst", `CCT_RST_64, v)
        wb(1'h0, 8'h20, 32'h0);
        `CHK("unmapped", `CCT_RST_32, rd)
        wr64(`CCT_A_CMP_HI, 64'h0123_4567_89ab_c000);
        rd64(`CCT_A_CMP_HI);
        `CHK("cmp_set", 64'h0123_4567_89ab_c000, v)
        rd64(`CCT_A_CMP_HI);
        `CHK("cmp_keep", 64'h0123_4567_89ab_c000, v)
        wb(1'h1, `CCT_A_CTRL, 32'h3);
        set_tod(64'h0123_4567_89ab_cfff);
        `CHK("cc_low", 1'h0, req.cc_req)
        set_tod(64'h0123_4567_89ab_d000);
        `CHK("cc_req", 1'h1, req.cc_req)
        `CHK("ext_int", 1'h1, ext_int)
        wb(1'h1, `CCT_A_CTRL, 32'h1);
        repeat (3) @(posedge clk_i);
        `CHK("cc_mask", 1'h0, req.cc_req)
        `CHK("ext_off", 1'h0, ext_int)
        wb(1'h0, `CCT_A_STAT, 32'h0);
        `CHK("cc_live", 1'h1, rd[`CCT_B_CC_LIVE])
        set_tod(64'h0123_4567_89ab_b000);
        wb(1'h0, `CCT_A_STAT, 32'h0);
        `CHK("cc_gone", 1'h0, rd[`CCT_B_CC_LIVE])
        wb(1'h1, `CCT_A_CTRL, 32'h3);
        set_tod(64'h0123_4567_89ab_c000);
        stopped <= 1'h1;
        `CHK("cc_equal", 1'h0, req.cc_req)
        sync();
        repeat (3) @(posedge clk_i);
        `CHK("cc_stopped", 1'h1, req.cc_req)
        stopped <= 1'h0;
        wb(1'h1, `CCT_A_CTRL, 32'h5);
        sync();
        wr64(`CCT_A_TMR_HI, `CCT_TMR_STEP);
        rd64(`CCT_A_TMR_HI);
        `CHK("tmr_set", `CCT_TMR_STEP, v)
        sync();
        // enable low across two would-be strobes: the timer must not move
        ce_i <= 1'h0;
        repeat (100) @(posedge clk_i);
        ce_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rd64(`CCT_A_TMR_HI);
        `CHK("tmr_step", `CCT_RST_64, v)
        `CHK("tm_zero", 1'h0, req.tm_req)
        sync();
        repeat (2) @(posedge clk_i);
        `CHK("tm_neg", 1'h1, req.tm_req)
        rd64(`CCT_A_TMR_HI);
        `CHK("tmr_sign", 64'hffff_ffff_ffff_f000, v)
        sync();
        repeat (2) @(posedge clk_i);
        `CHK("tm_hold", 1'h1, req.tm_req)
        stopped <= 1'h1;
        sync();
        sync();
        rd64(`CCT_A_TMR_HI);
        `CHK("tmr_stop", 64'hffff_ffff_ffff_e000, v)
        wb(1'h1, `CCT_A_IEN, 32'h2);
        wb(1'h1, `CCT_A_ICLR, 32'h2);
        repeat (3) @(posedge clk_i);
        `CHK("irq_tm", 1'h1, irq)
        wr64(`CCT_A_TMR_HI, 64'h0000_0000_0010_0000);
        repeat (2) @(posedge clk_i);
        `CHK("tm_drop", 1'h0, req.tm_req)
        wb(1'h0, `CCT_A_STAT, 32'h0);
        `CHK("tm_live", 1'h0, rd[`CCT_B_TM_LIVE])
        wb(1'h1, `CCT_A_ICLR, 32'h2);
        repeat (3) @(posedge clk_i);
        `CHK("irq_clr", 1'h0, irq)
        wb(1'h1, `CCT_A_IEN, 32'h1);
        repeat (3) @(posedge clk_i);
        `CHK("irq_cc", 1'h1, irq)
        ipr <= 1'h1;
        @(posedge clk_i);
        ipr <= 1'h0;
        rd64(`CCT_A_CMP_HI);
        `CHK("cmp_ipr", `CCT_RST_64, v)
        rd64(`CCT_A_TMR_HI);
        `CHK("tmr_ipr", `CCT_RST_64, v)
        wrap_up();
    end
endmodule
`default_nettype wire
